// File: logic/ofts_top.sv
// output force test word, control word and agc capture behind the processor port
// ****************************************************************
// What this block does
// the processor writes the forced pin word to destination address 8.
// in test mode the five phase pins follow word bits 4 to 0, bit 4 on the top pin.
// in test mode the sample strobe pin follows word bit 5.
// in test mode the level compare pin follows word bit 6.
// in test mode the ten in-phase pins follow word bits 16 to 7, bit 16 on the top pin.
// in test mode the data ready pin follows word bit 17.
// in test mode the oscillator tick pin follows word bit 18.
// in test mode the ten quadrature pins follow word bits 28 to 19.
// test mode is bit 3 of the control word at destination 4 and forcing acts only while it is set.
// any write to destination 9 captures the agc accumulator into a holding register.
// the captured agc value is read back a byte at a time over the eight data lines.
// normally the phase pins show accumulator bits 28:24, 29:25, 30:26 or 31:27 by a two bit select.
// word bit 28 feeds the top quadrature pin.
// with test mode off every pin returns to its functional source.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "ofts_cfg.svh"
module ofts_top
	import ofts_pkg::*;
#(
	parameter int AGC_W = 32
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// processor port
	input wire logic [2:0] ctl_addr,
	input wire logic ctl_wr,
	input wire logic ctl_rd,
	input wire logic [7:0] control_data_lines_in,
	output logic [7:0] control_data_lines_out,
	output logic control_data_lines_oe,
	// functional sources
	input wire logic [31:0] phase_acc,
	input wire logic norm_sample_strobe,
	input wire logic norm_level_compare,
	input wire logic [9:0] norm_inphase,
	input wire logic norm_data_ready,
	input wire logic norm_osc_tick,
	input wire logic [9:0] norm_quadrature,
	input wire logic [AGC_W-1:0] agc_accum,
	// output pins
	output logic [4:0] sample_phase_pins,
	output logic sample_strobe_pin,
	output logic level_compare_pin,
	output logic [9:0] inphase_out_pins,
	output logic output_data_ready,
	output logic osc_tick_pin,
	output logic [9:0] quadrature_out_pins
);
	// ****************************************************************
	// register file
	// ****************************************************************
	logic [31:0] hold;
	logic [31:0] next_hold;
	logic [`OFTS_CTRL_W-1:0] ctrl_word;
	logic [`OFTS_CTRL_W-1:0] next_ctrl_word;
	logic [31:0] output_force_word;
	logic [31:0] next_output_force_word;
	logic [AGC_W-1:0] agc_hold;
	logic [AGC_W-1:0] next_agc_hold;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic rd_oe;
	logic next_rd_oe;
	logic [31:0] agc_pad;
	logic dest_wr;
	logic test_en;

	assign dest_wr = ctl_wr && (ctl_addr == `OFTS_A_DEST);
	assign test_en = ctrl_word[`OFTS_CTRL_TEST];
	assign agc_pad = 32'(agc_hold);

	// bytes gather in the holding word, a destination write moves them
	always_comb begin
		next_hold = hold;
		next_ctrl_word = ctrl_word;
		next_output_force_word = output_force_word;
		next_agc_hold = agc_hold;
		if (ctl_wr && (ctl_addr <= `OFTS_A_HOLD_LAST)) begin
			next_hold[ctl_addr[1:0]*8 +: 8] = control_data_lines_in;
		end
		if (dest_wr) begin
			unique case (control_data_lines_in)
				`OFTS_D_CTRL: begin
					next_ctrl_word = hold[`OFTS_CTRL_W-1:0];
				end
				`OFTS_D_FORCE: begin
					next_output_force_word = hold;
				end
				`OFTS_D_AGC: begin
					// the data written is ignored, the write itself is the strobe
					next_agc_hold = agc_accum;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold <= 32'h00000000;
			ctrl_word <= `OFTS_CTRL_RST;
			output_force_word <= `OFTS_FORCE_RST;
			agc_hold <= '0;
		end else begin
			hold <= next_hold;
			ctrl_word <= next_ctrl_word;
			output_force_word <= next_output_force_word;
			agc_hold <= next_agc_hold;
		end
	end

	// ****************************************************************
	// read back of the captured agc value
	// ****************************************************************
	// byte chosen by the low address bits, driven one cycle after the read
	always_comb begin
		next_rd_oe = ctl_rd;
		next_rdata = rdata;
		if (ctl_rd) begin
			next_rdata = agc_pad[ctl_addr[1:0]*8 +: 8];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
			rd_oe <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rd_oe <= next_rd_oe;
		end
	end

	assign control_data_lines_out = rdata;
	assign control_data_lines_oe = rd_oe;

	// ****************************************************************
	// functional phase pin source
	// ****************************************************************
	ofts_win_t win_sel;
	logic [4:0] phase_win;
	logic [4:0] phase_held;
	logic [4:0] next_phase_held;

	assign win_sel = ofts_win_t'(ctrl_word[`OFTS_CTRL_SEL_HI:`OFTS_CTRL_SEL_LO]);

	// window into the top eight accumulator bits
	always_comb begin
		unique case (win_sel)
			OFTS_WIN_28_24: phase_win = phase_acc[28:24];
			OFTS_WIN_29_25: phase_win = phase_acc[29:25];
			OFTS_WIN_30_26: phase_win = phase_acc[30:26];
			OFTS_WIN_31_27: phase_win = phase_acc[31:27];
		endcase
	end

	// continuous update or only on data ready, as the control word says
	always_comb begin
		next_phase_held = phase_held;
		if (ctrl_word[`OFTS_CTRL_CONT] || norm_data_ready) begin
			next_phase_held = phase_win;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_held <= 5'h00;
		end else begin
			phase_held <= next_phase_held;
		end
	end

	// ****************************************************************
	// pin selectors, one per forced field
	// ****************************************************************
	// phase pins, bit 4 to the top pin
	ofts_force_mux #(.W(5)) u_sph (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(phase_held),
		.forced(output_force_word[`OFTS_F_SPH_HI:`OFTS_F_SPH_LO]),
		.q(sample_phase_pins)
	);
	ofts_force_mux #(.W(1)) u_strb (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_sample_strobe),
		.forced(output_force_word[`OFTS_F_STRB]),
		.q(sample_strobe_pin)
	);
	ofts_force_mux #(.W(1)) u_lvl (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_level_compare),
		.forced(output_force_word[`OFTS_F_LVL]),
		.q(level_compare_pin)
	);
	ofts_force_mux #(.W(10)) u_iout (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_inphase),
		.forced(output_force_word[`OFTS_F_I_HI:`OFTS_F_I_LO]),
		.q(inphase_out_pins)
	);
	ofts_force_mux #(.W(1)) u_drdy (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_data_ready),
		.forced(output_force_word[`OFTS_F_DRDY]),
		.q(output_data_ready)
	);
	ofts_force_mux #(.W(1)) u_tick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_osc_tick),
		.forced(output_force_word[`OFTS_F_TICK]),
		.q(osc_tick_pin)
	);
	// bit 28 lands on the top quadrature pin
	ofts_force_mux #(.W(10)) u_qout (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.test_en(test_en),
		.normal(norm_quadrature),
		.forced(output_force_word[`OFTS_F_Q_HI:`OFTS_F_Q_LO]),
		.q(quadrature_out_pins)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking chk_cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// read byte found by shifting, kept apart from the read mux it checks
	logic [7:0] chk_rd_byte;
	assign chk_rd_byte = 8'(agc_pad >> {ctl_addr[1:0], 3'b000});

	sequence s_load_force;
		dest_wr && (control_data_lines_in == `OFTS_D_FORCE);
	endsequence
	sequence s_agc_strobe;
		dest_wr && (control_data_lines_in == `OFTS_D_AGC);
	endsequence
	sequence s_test_on;
		test_en;
	endsequence

	chk_force_load: assert property (s_load_force |=> output_force_word == $past(hold))
		else $error("force word not loaded from holding bytes");
	chk_force_phase: assert property (s_test_on |=> sample_phase_pins == $past(output_force_word[4:0]))
		else $error("phase pins not forced");
	chk_force_strobe: assert property (s_test_on |=> sample_strobe_pin == $past(output_force_word[5]))
		else $error("strobe pin not forced");
	chk_force_level: assert property (s_test_on |=> level_compare_pin == $past(output_force_word[6]))
		else $error("level pin not forced");
	chk_force_inphase: assert property (s_test_on |=> inphase_out_pins == $past(output_force_word[16:7]))
		else $error("inphase pins not forced");
	chk_force_ready: assert property (s_test_on |=> output_data_ready == $past(output_force_word[17]))
		else $error("data ready pin not forced");
	chk_force_tick: assert property (s_test_on |=> osc_tick_pin == $past(output_force_word[18]))
		else $error("tick pin not forced");
	chk_force_quad: assert property (s_test_on |=> quadrature_out_pins == $past(output_force_word[28:19]))
		else $error("quadrature pins not forced");
	chk_test_enable: assert property ((dest_wr && control_data_lines_in == `OFTS_D_CTRL)
		|=> test_en == $past(hold[3]))
		else $error("test enable not taken from control bit 3");
	chk_agc_capture: assert property (s_agc_strobe |=> agc_hold == $past(agc_accum) ##1 $stable(agc_hold)
		or s_agc_strobe)
		else $error("agc accumulator not captured");
	chk_agc_read: assert property (ctl_rd |=> control_data_lines_oe
		&& control_data_lines_out == $past(chk_rd_byte))
		else $error("agc byte not read back");
	chk_phase_window: assert property ((!test_en && ctrl_word[13] && win_sel == OFTS_WIN_31_27)[*2]
		|=> sample_phase_pins == $past(phase_acc[31:27], 2))
		else $error("phase window wrong");
	// the edge that releases reset still resets the pins, so it starts no attempt
	chk_normal_path: assert property (rst_n && !test_en |=> inphase_out_pins == $past(norm_inphase)
		&& osc_tick_pin == $past(norm_osc_tick))
		else $error("pins not back on functional source");
endmodule // ofts_top
`default_nettype wire

// File: logic/ofts_cfg.svh
// offsets, field positions and reset values for the output force test block
`ifndef OFTS_CFG_SVH
`define OFTS_CFG_SVH

// ****************************************************************
// processor port addresses (three address lines)
// ****************************************************************
`define OFTS_A_HOLD_LAST 3'h3
`define OFTS_A_DEST 3'h4

// ****************************************************************
// destination addresses
// ****************************************************************
`define OFTS_D_CTRL 8'h04
`define OFTS_D_FORCE 8'h08
`define OFTS_D_AGC 8'h09

// ****************************************************************
// control word fields (destination 4)
// ****************************************************************
`define OFTS_CTRL_W 15
`define OFTS_CTRL_TEST 3
`define OFTS_CTRL_SEL_LO 11
`define OFTS_CTRL_SEL_HI 12
`define OFTS_CTRL_CONT 13
`define OFTS_CTRL_RST 15'h0000

// ****************************************************************
// output force word fields (destination 8)
// ****************************************************************
`define OFTS_F_SPH_HI 4
`define OFTS_F_SPH_LO 0
`define OFTS_F_STRB 5
`define OFTS_F_LVL 6
`define OFTS_F_I_HI 16
`define OFTS_F_I_LO 7
`define OFTS_F_DRDY 17
`define OFTS_F_TICK 18
`define OFTS_F_Q_HI 28
`define OFTS_F_Q_LO 19
`define OFTS_FORCE_RST 32'h00000000

`endif

// File: logic/ofts_pkg.sv
// types shared by the output force test block
`default_nettype none
package ofts_pkg;
	// window of the re-sampler phase accumulator shown on the phase pins
	typedef enum logic [1:0] {
		OFTS_WIN_28_24 = 2'h0,
		OFTS_WIN_29_25 = 2'h1,
		OFTS_WIN_30_26 = 2'h2,
		OFTS_WIN_31_27 = 2'h3
	} ofts_win_t;
endpackage
`default_nettype wire

// File: logic/ofts_force_mux.sv
// registered selector between a functional source and a forced test value
`timescale 1ns/1ps
`default_nettype none
module ofts_force_mux #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// select and sources
	input wire logic test_en,
	input wire logic [W-1:0] normal,
	input wire logic [W-1:0] forced,
	// pin value
	output logic [W-1:0] q
);
	logic [W-1:0] next_q;

	// forced value only while test mode is on
	always_comb begin
		next_q = test_en ? forced : normal;
	end

	// pins always come from a flop so they stay glitch free
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
endmodule // ofts_force_mux
`default_nettype wire

// File: tb/ofts_cpu_model.sv
// processor model driving the control port of the output force test block
`timescale 1ns/1ps
`default_nettype none
`include "ofts_cfg.svh"
module ofts_cpu_model (
	// clock
	input wire logic ref_clk,
	// control port requests
	output logic [2:0] ctl_addr,
	output logic ctl_wr,
	output logic ctl_rd,
	output logic [7:0] cpu_data,
	output logic cpu_oe,
	// shared data lines as resolved on the board
	input wire logic [7:0] control_data_lines,
	input wire logic device_oe
);
	// idle port at time zero
	initial begin
		ctl_addr = 3'h0;
		ctl_wr = 1'b0;
		ctl_rd = 1'b0;
		cpu_data = 8'h00;
		cpu_oe = 1'b0;
	end

	// one write per cycle; strobe stays up across back-to-back writes
	task automatic put(input logic [2:0] a, input logic [7:0] d);
		ctl_addr <= a;
		cpu_data <= d;
		ctl_wr <= 1'b1;
		cpu_oe <= 1'b1;
		@(posedge ref_clk);
	endtask

	// holding bytes low first, then the destination write
	task automatic dest(input logic [7:0] dst, input logic [31:0] w);
		for (int i = 0; i < 4; i++) begin
			put(3'(i), w[8*i +: 8]);
		end
		put(`OFTS_A_DEST, dst);
		ctl_wr <= 1'b0;
		cpu_oe <= 1'b0;
		@(posedge ref_clk);
	endtask

	// one byte of the agc capture, taken once the registered answer lands
	task automatic get(input logic [1:0] b, output logic [7:0] v, output logic en);
		ctl_addr <= {1'b0, b};
		ctl_rd <= 1'b1;
		@(posedge ref_clk);
		ctl_rd <= 1'b0;
		#1;
		v = control_data_lines;
		en = device_oe;
		@(posedge ref_clk);
	endtask
endmodule // ofts_cpu_model
`default_nettype wire

// File: tb/ofts_top_tb_top.sv
// self-checking testbench for the output force test block
`timescale 1ns/1ps
`default_nettype none
`include "ofts_cfg.svh"
module ofts_top_tb_top;
	import ofts_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] ctl_addr;
	logic ctl_wr;
	logic ctl_rd;
	logic [7:0] cpu_data;
	logic cpu_oe;
	logic [7:0] dout;
	logic doe;
	wire logic [7:0] lines;
	logic [31:0] phase_acc = 32'hC3A5_5A3C;
	logic n_strb = 1'b1;
	logic n_lvl = 1'b0;
	logic [9:0] n_i = 10'h2C5;
	logic n_rdy = 1'b1;
	logic n_tick = 1'b0;
	logic [9:0] n_q = 10'h13A;
	logic [31:0] agc = 32'h0;
	logic [4:0] sph;
	logic strb;
	logic lvl;
	logic [9:0] iout;
	logic rdy;
	logic tick;
	logic [9:0] qout;
	logic [7:0] v;
	logic en;
	int err_total = 0;
	int checked = 0;

	// released lines show the inverse of the last device byte, never a stale match
	assign lines = doe ? dout : (cpu_oe ? cpu_data : ~dout);

	// clock at 20 MHz
	always #25 ref_clk = ~ref_clk;

	ofts_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ctl_addr(ctl_addr), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
		.control_data_lines_in(lines), .control_data_lines_out(dout), .control_data_lines_oe(doe),
		.phase_acc(phase_acc), .norm_sample_strobe(n_strb), .norm_level_compare(n_lvl),
		.norm_inphase(n_i), .norm_data_ready(n_rdy), .norm_osc_tick(n_tick), .norm_quadrature(n_q),
		.agc_accum(agc), .sample_phase_pins(sph), .sample_strobe_pin(strb), .level_compare_pin(lvl),
		.inphase_out_pins(iout), .output_data_ready(rdy), .osc_tick_pin(tick), .quadrature_out_pins(qout));

	ofts_cpu_model i_cpu (.ref_clk(ref_clk), .ctl_addr(ctl_addr), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
		.cpu_data(cpu_data), .cpu_oe(cpu_oe), .control_data_lines(lines), .device_oe(doe));

	// ****************************************************************
	// checking helpers
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// pins need two edges after a destination write, phase pins three; three leaves margin
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// forced pin fields, then realign to an edge
	task automatic forced(input logic [31:0] w);
		settle();
		chk("phase", 32'(sph), 32'(w[4:0]));
		chk("strobe", 32'(strb), 32'(w[5]));
		chk("level", 32'(lvl), 32'(w[6]));
		chk("inphase", 32'(iout), 32'(w[16:7]));
		chk("ready", 32'(rdy), 32'(w[17]));
		chk("tick", 32'(tick), 32'(w[18]));
		chk("quad", 32'(qout), 32'(w[28:19]));
		@(posedge ref_clk);
	endtask

	// functional sources on the pins for window select sel
	task automatic normal(input int sel);
		settle();
		chk("phase", 32'(sph), 32'(phase_acc[24+sel +: 5]));
		chk("strobe", 32'(strb), 32'(n_strb));
		chk("level", 32'(lvl), 32'(n_lvl));
		chk("inphase", 32'(iout), 32'(n_i));
		chk("ready", 32'(rdy), 32'(n_rdy));
		chk("tick", 32'(tick), 32'(n_tick));
		chk("quad", 32'(qout), 32'(n_q));
		@(posedge ref_clk);
	endtask

	// ****************************************************************
	// closing and watchdog
	// ****************************************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// the whole sequence needs about 110 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		@(posedge ref_clk);
		#1;
		chk("oe in reset", 32'(doe), 32'h0);
		chk("phase in reset", 32'(sph), 32'h0);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// every window with continuous phase update, test mode off
		for (int s = 0; s < 4; s++) begin
			i_cpu.dest(`OFTS_D_CTRL, 32'h0000_2000 | (s << 11));
			normal(s);
		end
		$display("test normal done");
		// a force word alone leaves the pins functional
		i_cpu.dest(`OFTS_D_FORCE, 32'h1555_5555);
		normal(3);
		i_cpu.dest(`OFTS_D_CTRL, 32'h0000_2008);
		forced(32'h1555_5555);
		i_cpu.dest(`OFTS_D_FORCE, 32'h0AAA_AAAA);
		forced(32'h0AAA_AAAA);
		// forcing ends with the test bit, sources moved meanwhile
		n_strb <= 1'b0;
		n_lvl <= 1'b1;
		n_i <= 10'h1D2;
		n_rdy <= 1'b0;
		n_tick <= 1'b1;
		n_q <= 10'h2E9;
		i_cpu.dest(`OFTS_D_CTRL, 32'h0000_2000);
		normal(0);
		// update on data ready only: the phase pins keep bits 28:24 of the old accumulator
		i_cpu.dest(`OFTS_D_CTRL, 32'h0000_0000);
		phase_acc <= 32'h5A00_0000;
		settle();
		chk("phase held", 32'(sph), 32'h0000_0003);
		@(posedge ref_clk);
		n_rdy <= 1'b1;
		normal(0);
		$display("test force done");
		// capture then move the accumulator; readback must show the old value
		agc <= 32'h89AB_CDEF;
		@(posedge ref_clk);
		i_cpu.dest(`OFTS_D_AGC, 32'h0000_0000);
		agc <= 32'h1234_5678;
		for (int b = 0; b < 4; b++) begin
			i_cpu.get(2'(b), v, en);
			chk("agc byte", 32'(v), 32'((32'h89AB_CDEF >> (8*b)) & 32'hFF));
			chk("agc oe", 32'(en), 32'h1);
		end
		#1;
		chk("oe released", 32'(doe), 32'h0);
		$display("test agc done");
		stop_test();
	end
endmodule // ofts_top_tb_top
`default_nettype wire
